// *** design/tsi_params.svh ***
// timing, address and reset constants of the sensor serial slave
`ifndef TSI_PARAMS_SVH
`define TSI_PARAMS_SVH

// clock and timing figures in their own units
`define TSI_CLK_HZ      40000000
`define TSI_CLK_NS      25
`define TSI_TMO_MS      30
`define TSI_FILT_NRM_NS 100
`define TSI_FILT_HS_NS  25

// widths
`define TSI_TMO_W       24
`define TSI_FCNT_W      4

// bus values
`define TSI_BITS        4'h8
`define TSI_PTR_RST     8'h00
`define TSI_GC_ADDR     7'h00
`define TSI_HS_CODE     5'h01
`define TSI_ADDR_BASE   7'h40
`define TSI_ADDR_SCLGRP 7'h04
`define TSI_ADDR_VSSGRP 7'h08
`define TSI_STRAP_SCL   2'h3
`define TSI_PIN_IDLE    1'b1
`define TSI_NBYTE_HI    2'h1
`define TSI_NBYTE_LO    2'h2

`endif

// *** design/tsi_pkg.sv ***
// types shared by the sensor serial slave modules
`include "tsi_params.svh"

package tsi_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_RX,
    ST_TX,
    ST_MACK
  } tsi_state_e;

  typedef struct packed {
    logic       valid;
    logic       lo;
    logic [7:0] data;
  } tsi_wr_s;

  typedef struct packed {
    logic [2:0]             sync;
    logic [`TSI_FCNT_W-1:0] cnt;
    logic                   out;
  } tsi_filt_s;

  typedef struct packed {
    tsi_state_e            st;
    logic                  scl_q;
    logic                  sda_q;
    logic [3:0]            bit_cnt;
    logic [7:0]            shreg;
    logic                  rw;
    logic                  gc;
    logic                  first;
    logic [1:0]            nbyte;
    logic                  tx_lo;
    logic                  hs;
    logic [7:0]            ptr;
    logic                  sda_oe;
    logic                  sda_o;
    logic [`TSI_TMO_W-1:0] tmo_cnt;
    logic                  tmo;
    logic [6:0]            addr;
    logic                  strap_done;
    logic                  busy;
    tsi_wr_s               wr;
  } tsi_core_s;

endpackage

// *** design/tsi_in_filt.sv ***
// pin synchroniser and glitch filter with selectable depth
`timescale 1ns/1ps
`default_nettype none
`include "tsi_params.svh"

module tsi_in_filt (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // pin and depth
  input  wire logic                   pin_in,
  input  wire logic [`TSI_FCNT_W-1:0] depth,
  // filtered level
  output logic                        pin_flt
);

  tsi_pkg::tsi_filt_s q_ff;
  tsi_pkg::tsi_filt_s nxt_q;

  always_comb begin
    nxt_q      = q_ff;
    nxt_q.sync = {q_ff.sync[1:0], pin_in};
    // only stages two and three are looked at, stage one may be metastable
    if ((q_ff.sync[1] == q_ff.sync[2]) && (q_ff.sync[2] != q_ff.out)) begin
      if ((q_ff.cnt + `TSI_FCNT_W'(1)) >= depth) begin
        nxt_q.out = q_ff.sync[2];
        nxt_q.cnt = '0;
      end else begin
        nxt_q.cnt = q_ff.cnt + `TSI_FCNT_W'(1);
      end
    end else begin
      nxt_q.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_ff <= '{sync: {3{`TSI_PIN_IDLE}}, cnt: '0, out: `TSI_PIN_IDLE};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign pin_flt = q_ff.out;

endmodule
`default_nettype wire

// *** design/tsi_slave.sv ***
// two-wire slave bus logic of the temperature sensor
//
// Operation
// - normal speed filtering unless the high-speed code is the first byte
// - high-speed code is not acknowledged and selects the faster input filter
// - high-speed mode survives transfers and repeated starts until a stop or a timeout
// - a stop returns the input filters to the slow setting
// - general call address with write direction is acknowledged
// - general call: second byte acknowledged and dropped, later bytes not acked
// - zero address with read direction (start byte) is acknowledged
// - after a start byte the pointed register is sent upper byte first
// - pointer resets to the temperature register
// - scl low for the timeout resets the interface and releases sda
// - after a timeout all activity is ignored until a new start
// - start is sda falling while scl is high
// - stop is sda rising while scl is high
// - transfers open with start; stop or repeated start ends them
// - no limit on the number of data bytes, except after a general call
// - start or stop after the upper read byte abandons the lower and frees sda
// - acknowledge drives sda low across the ninth clock high phase
// - a master not-acknowledge ends the read and releases sda
// - idle bus: neither line is driven
// - slave only, scl is never driven
// - words go as two bytes, upper first, msb first
// - reads use the pointer from the latest write, pointer persists
// - 7-bit address from two strap pins plus direction bit
`timescale 1ns/1ps
`default_nettype none
`include "tsi_params.svh"

module tsi_slave #(
  parameter int TMO_CYC  = `TSI_TMO_MS * (`TSI_CLK_HZ / 1000),
  parameter int FILT_NRM = (`TSI_FILT_NRM_NS / `TSI_CLK_NS < 1) ? 1 :
                           (`TSI_FILT_NRM_NS / `TSI_CLK_NS),
  parameter int FILT_HS  = (`TSI_FILT_HS_NS / `TSI_CLK_NS < 1) ? 1 :
                           (`TSI_FILT_HS_NS / `TSI_CLK_NS)
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // bus pins (scl is input only)
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // address straps, coded 0 low, 1 high, 2 tied to sda, 3 tied to scl
  input  wire logic [1:0]  addr_strap_low,
  input  wire logic [1:0]  addr_strap_high,
  // register side
  input  wire logic [15:0] rd_data,
  output logic [7:0]       reg_ptr,
  output tsi_pkg::tsi_wr_s wr,
  // status
  output logic             hs_mode,
  output logic             tmo_pulse,
  output logic             bus_busy
);

  localparam logic [`TSI_TMO_W-1:0] TMO_LAST = `TSI_TMO_W'(TMO_CYC - 1);
  localparam logic [`TSI_TMO_W-1:0] TMO_SAT  = `TSI_TMO_W'(TMO_CYC);

  tsi_pkg::tsi_core_s q_ff;
  tsi_pkg::tsi_core_s nxt_q;

  logic                   scl_f;
  logic                   sda_f;
  logic [`TSI_FCNT_W-1:0] depth;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_c;
  logic                   stop_c;

  // the filter follows the registered mode, so a switch takes one cycle
  assign depth = q_ff.hs ? `TSI_FCNT_W'(FILT_HS) : `TSI_FCNT_W'(FILT_NRM);

  tsi_in_filt u_scl_filt (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (scl_in),
    .depth   (depth),
    .pin_flt (scl_f)
  );

  tsi_in_filt u_sda_filt (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (sda_in),
    .depth   (depth),
    .pin_flt (sda_f)
  );

  // both pins pass identical filters, so their order at the pins survives
  assign scl_rise = scl_f & ~q_ff.scl_q;
  assign scl_fall = ~scl_f & q_ff.scl_q;
  assign start_c  = scl_f & q_ff.scl_q & q_ff.sda_q & ~sda_f;
  assign stop_c   = scl_f & q_ff.scl_q & ~q_ff.sda_q & sda_f;

  always_comb begin
    nxt_q          = q_ff;
    nxt_q.wr.valid = 1'b0;
    nxt_q.tmo      = 1'b0;
    nxt_q.scl_q    = scl_f;
    nxt_q.sda_q    = sda_f;

    // straps are caught once, the cycle after reset release
    // a strap that moves later goes unseen until the next reset
    if (!q_ff.strap_done) begin
      nxt_q.addr       = `TSI_ADDR_BASE
                       | ((addr_strap_high == `TSI_STRAP_SCL) ? `TSI_ADDR_SCLGRP
                                                              : `TSI_ADDR_VSSGRP)
                       | {5'h00, addr_strap_low};
      nxt_q.strap_done = 1'b1;
    end

    // saturating low-phase counter fires exactly once per stuck low
    if (scl_f) begin
      nxt_q.tmo_cnt = '0;
    end else if (q_ff.tmo_cnt != TMO_SAT) begin
      nxt_q.tmo_cnt = q_ff.tmo_cnt + `TSI_TMO_W'(1);
    end

    // the timeout outranks a start or stop seen in the same cycle
    if (!scl_f && (q_ff.tmo_cnt == TMO_LAST)) begin
      nxt_q.st     = tsi_pkg::ST_IDLE;
      nxt_q.sda_oe = 1'b0;
      nxt_q.hs     = 1'b0;
      nxt_q.tmo    = 1'b1;
    end else if (start_c) begin
      // repeated start keeps high-speed mode
      nxt_q.st      = tsi_pkg::ST_ADDR;
      nxt_q.bit_cnt = '0;
      nxt_q.first   = 1'b1;
      nxt_q.sda_oe  = 1'b0;
    end else if (stop_c) begin
      nxt_q.st     = tsi_pkg::ST_IDLE;
      nxt_q.sda_oe = 1'b0;
      nxt_q.hs     = 1'b0;
    end else begin
      case (q_ff.st)
        tsi_pkg::ST_IDLE: begin
          nxt_q.sda_oe = 1'b0;
        end

        tsi_pkg::ST_ADDR,
        tsi_pkg::ST_RX: begin
          if (scl_rise && (q_ff.bit_cnt < `TSI_BITS)) begin
            nxt_q.shreg   = {q_ff.shreg[6:0], sda_f};
            nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
          end else if (scl_fall && (q_ff.bit_cnt == `TSI_BITS)) begin
            nxt_q.bit_cnt = '0;
            nxt_q.first   = 1'b0;
            if (q_ff.st == tsi_pkg::ST_ADDR) begin
              if (q_ff.first && (q_ff.shreg[7:3] == `TSI_HS_CODE)) begin
                // no acknowledge, wait for the repeated start and address
                nxt_q.hs = 1'b1;
                nxt_q.st = tsi_pkg::ST_IDLE;
              end else if (q_ff.shreg[7:1] == q_ff.addr) begin
                nxt_q.gc     = 1'b0;
                nxt_q.rw     = q_ff.shreg[0];
                nxt_q.nbyte  = '0;
                nxt_q.tx_lo  = 1'b0;
                nxt_q.st     = tsi_pkg::ST_ACK;
                nxt_q.sda_oe = 1'b1;
              end else if (q_ff.shreg[7:1] == `TSI_GC_ADDR) begin
                nxt_q.gc     = ~q_ff.shreg[0];
                nxt_q.rw     = q_ff.shreg[0];
                nxt_q.nbyte  = '0;
                nxt_q.tx_lo  = 1'b0;
                nxt_q.st     = tsi_pkg::ST_ACK;
                nxt_q.sda_oe = 1'b1;
              end else begin
                // not ours: keep off the bus until the next start or stop
                nxt_q.st = tsi_pkg::ST_IDLE;
              end
            end else if (q_ff.gc) begin
              // the first general call data byte is acked, later ones not; none reaches the pointer
              if (q_ff.nbyte == 2'h0) begin
                nxt_q.nbyte  = `TSI_NBYTE_HI;
                nxt_q.st     = tsi_pkg::ST_ACK;
                nxt_q.sda_oe = 1'b1;
              end else begin
                nxt_q.st = tsi_pkg::ST_IDLE;
              end
            end else begin
              if (q_ff.nbyte == 2'h0) begin
                nxt_q.ptr = q_ff.shreg;
              end else begin
                nxt_q.wr.valid = 1'b1;
                nxt_q.wr.lo    = (q_ff.nbyte == `TSI_NBYTE_LO);
                nxt_q.wr.data  = q_ff.shreg;
              end
              // byte index wraps over word pairs, no count limit
              nxt_q.nbyte  = (q_ff.nbyte == `TSI_NBYTE_LO) ? `TSI_NBYTE_HI
                                                           : q_ff.nbyte + 2'h1;
              nxt_q.st     = tsi_pkg::ST_ACK;
              nxt_q.sda_oe = 1'b1;
            end
          end
        end

        tsi_pkg::ST_ACK: begin
          // low held from the eighth fall to the ninth fall
          if (scl_fall) begin
            nxt_q.bit_cnt = 4'h1;
            if (q_ff.rw) begin
              // rd_data is taken at this edge; the register side holds it then
              nxt_q.shreg  = {rd_data[14:8], 1'b0};
              nxt_q.sda_oe = ~rd_data[15];
              nxt_q.st     = tsi_pkg::ST_TX;
            end else begin
              // write: free the ack and collect the next byte
              nxt_q.bit_cnt = '0;
              nxt_q.sda_oe  = 1'b0;
              nxt_q.st      = tsi_pkg::ST_RX;
            end
          end
        end

        tsi_pkg::ST_TX: begin
          // data moves one cycle after the filtered fall, inside scl low
          if (scl_fall) begin
            if (q_ff.bit_cnt < `TSI_BITS) begin
              nxt_q.sda_oe  = ~q_ff.shreg[7];
              nxt_q.shreg   = {q_ff.shreg[6:0], 1'b0};
              nxt_q.bit_cnt = q_ff.bit_cnt + 4'h1;
            end else begin
              nxt_q.sda_oe = 1'b0;
              nxt_q.st     = tsi_pkg::ST_MACK;
            end
          end
        end

        tsi_pkg::ST_MACK: begin
          if (scl_rise && sda_f) begin
            nxt_q.st = tsi_pkg::ST_IDLE;
          end else if (scl_fall) begin
            // upper and lower bytes alternate for as long as the master acks
            nxt_q.tx_lo   = ~q_ff.tx_lo;
            nxt_q.bit_cnt = 4'h1;
            nxt_q.st      = tsi_pkg::ST_TX;
            if (q_ff.tx_lo) begin
              nxt_q.shreg  = {rd_data[14:8], 1'b0};
              nxt_q.sda_oe = ~rd_data[15];
            end else begin
              nxt_q.shreg  = {rd_data[6:0], 1'b0};
              nxt_q.sda_oe = ~rd_data[7];
            end
          end
        end

        default: begin
          nxt_q.st     = tsi_pkg::ST_IDLE;
          nxt_q.sda_oe = 1'b0;
        end
      endcase
    end

    // registered so the status pin comes straight from a flop
    nxt_q.busy = (nxt_q.st != tsi_pkg::ST_IDLE);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_ff <= '{
        st:         tsi_pkg::ST_IDLE,
        scl_q:      `TSI_PIN_IDLE,
        sda_q:      `TSI_PIN_IDLE,
        bit_cnt:    4'h0,
        shreg:      8'h00,
        rw:         1'b0,
        gc:         1'b0,
        first:      1'b0,
        nbyte:      2'h0,
        tx_lo:      1'b0,
        hs:         1'b0,
        ptr:        `TSI_PTR_RST,
        sda_oe:     1'b0,
        sda_o:      1'b0,
        tmo_cnt:    '0,
        tmo:        1'b0,
        addr:       7'h00,
        strap_done: 1'b0,
        busy:       1'b0,
        wr:         '{valid: 1'b0, lo: 1'b0, data: 8'h00}
      };
    end else begin
      q_ff <= nxt_q;
    end
  end

  // open drain: the driven level is always low, scl has no driver at all
  assign sda_out   = q_ff.sda_o;
  assign sda_oe    = q_ff.sda_oe;
  assign reg_ptr   = q_ff.ptr;
  assign wr        = q_ff.wr;
  assign hs_mode   = q_ff.hs;
  assign tmo_pulse = q_ff.tmo;
  assign bus_busy  = q_ff.busy;

endmodule
`default_nettype wire

// *** test/tsi_slave_assertions.sv ***
// port checks of the sensor serial slave
`timescale 1ns/1ps
`default_nettype none

module tsi_slave_assertions #(
  parameter int TMO_CYC = 1200000
) (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             rst,
  // bus
  input wire logic             scl_in,
  input wire logic             sda_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  // register side and status
  input wire logic [7:0]       reg_ptr,
  input wire tsi_pkg::tsi_wr_s wr,
  input wire logic             hs_mode,
  input wire logic             tmo_pulse,
  input wire logic             bus_busy
);
  // raw scl low time; the design counts filtered samples, so it lags this a little
  int low_cnt;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 0;
    end else if (scl_in) begin
      low_cnt <= 0;
    end else if (low_cnt < TMO_CYC + 50) begin
      low_cnt <= low_cnt + 1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  // stop, then scl high long enough for the filters to pass it
  sequence s_stop;
    scl_in && $rose(sda_in) ##1 scl_in [*8];
  endsequence

  property p_drive_low;
    // the pull is seen one cycle after it lands, so scl is judged a cycle back
    $rose(sda_oe) |-> !$past(scl_in) && bus_busy && !sda_out;
  endproperty
  property p_idle_rel;
    !bus_busy |-> !sda_oe;
  endproperty
  property p_start_busy;
    s_start |-> ##[1:12] bus_busy;
  endproperty
  property p_stop_idle;
    s_stop |=> !bus_busy && !hs_mode && !sda_oe;
  endproperty
  property p_hs_noack;
    $rose(hs_mode) |-> !sda_oe [*8];
  endproperty
  property p_tmo_due;
    low_cnt == TMO_CYC |-> ##[0:12] tmo_pulse;
  endproperty
  property p_tmo_early;
    tmo_pulse |-> low_cnt >= TMO_CYC + 2;
  endproperty
  property p_tmo_rel;
    tmo_pulse |=> !sda_oe && !bus_busy && !hs_mode;
  endproperty
  property p_wr_ack;
    wr.valid |-> sda_oe ##1 !wr.valid;
  endproperty
  property p_ptr_ack;
    $changed(reg_ptr) |-> ##[0:1] sda_oe;
  endproperty

  a_drive_low: assert property (p_drive_low) else $error("sda pulled outside scl low");
  a_idle_rel: assert property (p_idle_rel) else $error("sda driven while idle");
  a_start_busy: assert property (p_start_busy) else $error("start not seen");
  a_stop_idle: assert property (p_stop_idle) else $error("stop not ending transfer");
  a_hs_noack: assert property (p_hs_noack) else $error("high-speed code acked");
  a_tmo_due: assert property (p_tmo_due) else $error("timeout missing");
  a_tmo_early: assert property (p_tmo_early) else $error("timeout too early");
  a_tmo_rel: assert property (p_tmo_rel) else $error("timeout left bus held");
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");
  a_ptr_ack: assert property (p_ptr_ack) else $error("pointer moved without ack");
endmodule

bind tsi_slave tsi_slave_assertions #(.TMO_CYC(TMO_CYC)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .wr(wr),
  .hs_mode(hs_mode), .tmo_pulse(tmo_pulse), .bus_busy(bus_busy)
);
`default_nettype wire

// *** test/tsi_bus_master.sv ***
// two-wire bus master model for the sensor serial slave
`timescale 1ns/1ps
`default_nettype none

module tsi_bus_master #(
  // scl phase in clocks; kept above the filter depth, far above 1 kHz
  parameter int PH = 8
) (
  // clock
  input  wire logic ref_clk,
  // bus
  input  wire logic sda_in,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // also serves as repeated start from scl low
  task automatic start();
    sda_o = 1'b1;
    w(PH / 2);
    scl_o = 1'b1;
    w(PH);
    sda_o = 1'b0;
    w(PH);
    scl_o = 1'b0;
    w(PH / 2);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    w(PH / 2);
    scl_o = 1'b1;
    w(PH);
    sda_o = 1'b1;
    w(PH);
  endtask

  // eight bits then the ack bit; ones on tx release sda for reads
  task automatic xfer(input logic [7:0] tx, input logic ack_out,
                      output logic [7:0] rx, output logic ack_in);
    logic [8:0] v;
    logic [8:0] s;
    v = {tx, ack_out};
    for (int i = 8; i >= 0; i--) begin
      sda_o = v[i];
      w(PH / 2);
      scl_o = 1'b1;
      w(PH / 2);
      s[i] = sda_in;
      w(PH / 2);
      scl_o = 1'b0;
      w(PH / 2);
    end
    rx = s[8:1];
    ack_in = s[0];
  endtask
endmodule
`default_nettype wire

// *** test/tsi_slave_tb_top.sv ***
// self-checking bench of the sensor serial slave
`timescale 1ns/1ps
`default_nettype none

module tsi_slave_tb_top;
  localparam int TMO = 200;
  logic             ref_clk;
  logic             rst;
  logic             scl;
  logic             sda_m;
  logic             sda_oe;
  logic             hs_mode;
  logic             tmo_pulse;
  logic             bus_busy;
  logic [15:0]      rd_data;
  logic [1:0]       strap_low;
  logic [1:0]       strap_high;
  logic [7:0]       reg_ptr;
  logic [7:0]       q;
  logic             a;
  tsi_pkg::tsi_wr_s wr;
  tsi_pkg::tsi_wr_s wlog[$];
  int               failures;
  int               samples_checked;
  // open-drain line with pull-up
  wire logic        sda = sda_m & ~sda_oe;

  tsi_slave #(.TMO_CYC(TMO)) dut (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .addr_strap_low(strap_low), .addr_strap_high(strap_high),
    .rd_data(rd_data), .reg_ptr(reg_ptr), .wr(wr), .hs_mode(hs_mode),
    .tmo_pulse(tmo_pulse), .bus_busy(bus_busy)
  );
  tsi_bus_master m (.ref_clk(ref_clk), .sda_in(sda), .scl_o(scl), .sda_o(sda_m));

  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    if (wr.valid === 1'b1) begin
      wlog.push_back(wr);
    end
  end

  task automatic chk1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t bit got %b exp %b", $time, g, e);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("Error t=%0t byte got %h exp %h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_write();
    m.start();
    m.xfer(8'h90, 1'b1, q, a);
    chk1(a, 1'b0);
    chk1(hs_mode, 1'b0);
    m.xfer(8'h05, 1'b1, q, a);
    chk1(a, 1'b0);
    wlog.delete();
    for (int i = 0; i < 3; i++) begin
      m.xfer(8'h12 + 8'(i * 8'h22), 1'b1, q, a);
      chk1(a, 1'b0);
    end
    m.stop();
    chk8(reg_ptr, 8'h05);
    chk8(8'(wlog.size()), 8'h03);
    chk8(wlog[2].data, 8'h56);
    chk1(wlog[1].lo, 1'b1);
  endtask

  task automatic t_read();
    rd_data = 16'hb4e1;
    m.start();
    m.xfer(8'h91, 1'b1, q, a);
    chk1(a, 1'b0);
    m.xfer(8'hff, 1'b0, q, a);
    chk8(q, 8'hb4);
    m.xfer(8'hff, 1'b1, q, a);
    chk8(q, 8'he1);
    m.w(8);
    chk1(sda_oe, 1'b0);
    chk1(bus_busy, 1'b0);
    m.stop();
    chk8(reg_ptr, 8'h05);
  endtask

  task automatic t_gc();
    wlog.delete();
    m.start();
    m.xfer(8'h00, 1'b1, q, a);
    chk1(a, 1'b0);
    m.xfer(8'ha5, 1'b1, q, a);
    chk1(a, 1'b0);
    m.xfer(8'h5a, 1'b1, q, a);
    chk1(a, 1'b1);
    m.stop();
    chk8(8'(wlog.size()), 8'h00);
    chk8(reg_ptr, 8'h05);
  endtask

  task automatic t_sbyte();
    rd_data = 16'h7cbd;
    m.start();
    m.xfer(8'h01, 1'b1, q, a);
    chk1(a, 1'b0);
    m.xfer(8'hff, 1'b0, q, a);
    chk8(q, 8'h7c);
    m.xfer(8'hff, 1'b1, q, a);
    chk8(q, 8'hbd);
    m.stop();
    // cut a read after its upper byte, then an unknown address
    m.start();
    m.xfer(8'h91, 1'b1, q, a);
    m.xfer(8'hff, 1'b0, q, a);
    m.start();
    chk1(sda_oe, 1'b0);
    m.xfer(8'hee, 1'b1, q, a);
    chk1(a, 1'b1);
    chk8(q, 8'hee);
    m.stop();
  endtask

  task automatic t_strap();
    // a second reset takes the straps anew and clears the pointer
    @(negedge ref_clk) rst = 1'b1;
    strap_low = 2'h1;
    strap_high = 2'h3;
    m.w(4);
    rst = 1'b0;
    m.w(8);
    chk8(reg_ptr, 8'h00);
    m.start();
    m.xfer(8'h90, 1'b1, q, a);
    chk1(a, 1'b1);
    m.stop();
    m.start();
    m.xfer(8'h8a, 1'b1, q, a);
    chk1(a, 1'b0);
    m.xfer(8'h3c, 1'b1, q, a);
    chk1(a, 1'b0);
    m.stop();
    chk8(reg_ptr, 8'h3c);
  endtask

  task automatic t_hs();
    m.start();
    m.xfer(8'h08, 1'b1, q, a);
    chk1(a, 1'b1);
    chk1(hs_mode, 1'b1);
    m.start();
    m.xfer(8'h90, 1'b1, q, a);
    chk1(a, 1'b0);
    m.xfer(8'h07, 1'b1, q, a);
    m.start();
    chk1(hs_mode, 1'b1);
    m.xfer(8'h90, 1'b1, q, a);
    chk1(a, 1'b0);
    m.stop();
    chk1(hs_mode, 1'b0);
    chk8(reg_ptr, 8'h07);
  endtask

  task automatic t_tmo();
    int n;
    rd_data = 16'h0000;
    m.start();
    m.xfer(8'h91, 1'b1, q, a);
    m.w(4);
    chk1(sda_oe, 1'b1);
    n = 0;
    while (tmo_pulse !== 1'b1 && n < 400) begin
      m.w(1);
      n++;
    end
    if (n == 400) begin
      failures++;
      give_verdict();
    end
    m.w(2);
    chk1(sda_oe, 1'b0);
    m.xfer(8'h90, 1'b1, q, a);
    chk1(a, 1'b1);
    m.stop();
    m.start();
    m.xfer(8'h90, 1'b1, q, a);
    chk1(a, 1'b0);
    m.stop();
  endtask

  initial begin
    #1_000_000;
    failures++;
    give_verdict();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    rd_data = 16'h0000;
    strap_low = 2'h0;
    strap_high = 2'h0;
    failures = 0;
    samples_checked = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    m.w(8);
    chk8(reg_ptr, 8'h00);
    chk1(sda_oe, 1'b0);
    t_write();
    t_read();
    t_gc();
    t_sbyte();
    t_hs();
    t_tmo();
    t_strap();
    give_verdict();
  end
endmodule
`default_nettype wire
